// ==== hdl/lvps_pkg.sv ====
package lvps_pkg;

	// ************************************************************
	// Register map, APB byte offsets
	// ************************************************************
	localparam logic [11:0] LVPS_CTRL_OFS    = 12'h000;
	localparam logic [11:0] LVPS_SEL_OFS     = 12'h004;
	localparam logic [11:0] LVPS_STATE_OFS   = 12'h008;
	localparam logic [11:0] LVPS_IRQ_STS_OFS = 12'h00c;
	localparam logic [11:0] LVPS_IRQ_MSK_OFS = 12'h010;

	// Control fields
	localparam int LVPS_CTRL_ENABLE_BIT = 0;
	localparam int LVPS_CTRL_REPORT_BIT = 1;
	localparam int LVPS_CTRL_MODE_LSB   = 4;
	localparam logic [31:0] LVPS_CTRL_RESET = 32'h0000_0000;

	// Selection fields
	localparam int LVPS_SEL_GROUP_LSB  = 0;
	localparam int LVPS_SEL_MEMBER_LSB = 8;
	localparam logic [4:0] LVPS_GROUP_MIN  = 5'h01;
	localparam logic [4:0] LVPS_GROUP_MAX  = 5'h14;
	localparam logic [1:0] LVPS_MEMBER_MIN = 2'h1;
	localparam logic [1:0] LVPS_MEMBER_MAX = 2'h3;
	localparam logic [31:0] LVPS_SEL_RESET = 32'h0000_0101;

	// Interrupt status bits
	localparam int LVPS_IRQ_ALARM_BIT = 0;
	localparam int LVPS_IRQ_LOP_BIT   = 1;
	localparam int LVPS_IRQ_FAIL_BIT  = 2;
	localparam logic [2:0] LVPS_IRQ_RESET = 3'h0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int LVPS_CLK_HZ        = 50_000_000;
	localparam int LVPS_SWITCH_MAX_US = 1000;
	localparam int LVPS_SWITCH_CYCLES = 2;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		LVPS_MODE_VC2,
		LVPS_MODE_VC12,
		LVPS_MODE_VC11
	} lvps_mode_type;

	typedef struct packed {
		logic [7:0] data;
		logic       frame_start;
		logic       valid;
	} lvps_stream_type;

	typedef struct packed {
		logic alarm_defect;
		logic lop_defect;
	} lvps_defect_type;

endpackage : lvps_pkg

// ==== hdl/lvps_sink.sv ====
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// - Disabled instance sends all-ones data and reports no fault causes.
// - Alarm insert action is instance disabled or alarm defect or pointer loss or trail fail.
// - Server fail output follows alarm defect or pointer loss or trail fail.
// - All-ones substitution starts well within 1 ms of insert action.
// - Recovered data resumes well within 1 ms of insert action clearing.
// - Alarm fault cause needs alarm defect, no trail fail, report enabled.
// - Pointer loss cause needs pointer loss defect and no trail fail.
// - Alarm report enable is software configurable and resets to false.
// - VC-2 mode picks one TU-2 by group index 1 to 20.
// - VC-12 and VC-11 pick a TU-12 by group 1-20 and member 1-3.
// - Pointer bytes locate frame phase; defects come from the interpreter.
// - Three recovery modes, each giving data with frame phase.
// - Each instance may be deactivated to silence spurious pointer loss.
module lvps_sink (
	input  wire logic                      clk,
	input  wire logic                      srst,
	// APB slave
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic                           pready,
	output logic [31:0]                    prdata,
	output logic                           pslverr,
	// Group access point stream
	input  wire lvps_pkg::lvps_stream_type group_data_in,
	input  wire logic [4:0]                group_slot_index,
	input  wire logic [1:0]                member_slot_index,
	input  wire logic                      trail_fail_input,
	// Pointer interpreter results for the selected tributary
	input  wire lvps_pkg::lvps_defect_type pointer_defects,
	input  wire logic                      vc_phase_start,
	// Client side
	output lvps_pkg::lvps_stream_type      client_data_out,
	output logic                           client_server_fail_out,
	output logic                           alarm_fault_cause,
	output logic                           pointer_loss_fault_cause,
	output logic                           irq
);

	// ************************************************************
	// Register state
	// ************************************************************
	logic                  enable_reg;
	logic                  report_reg;
	lvps_pkg::lvps_mode_type mode_reg;
	logic [4:0]            group_sel_reg;
	logic [1:0]            member_sel_reg;
	logic [2:0]            irq_sts_reg;
	logic [2:0]            irq_msk_reg;
	logic [2:0]            irq_sts_next;
	logic                  insert_reg;
	logic                  cause_alarm_next;
	logic                  cause_lop_next;
	logic                  alarm_insert_action;
	logic                  server_fail_action;
	logic                  slot_match;
	logic                  sel_legal;
	logic                  wr_en;
	logic                  rd_en;
	logic [2:0]            events;
	logic [31:0]           rd_word;

	// Writes land only at the edge that completes the access
	assign wr_en = psel && penable && pwrite && pready;
	assign rd_en = psel && penable && !pwrite;

	// ************************************************************
	// Defect correlation and consequent actions
	// ************************************************************
	// Fault causes and interrupt events only count defects while this instance is active; server fail counts them always
	assign alarm_insert_action = !enable_reg || pointer_defects.alarm_defect
	                             || pointer_defects.lop_defect || trail_fail_input;
	assign server_fail_action  = pointer_defects.alarm_defect || pointer_defects.lop_defect
	                             || trail_fail_input;
	assign cause_alarm_next = enable_reg && pointer_defects.alarm_defect
	                          && !trail_fail_input && report_reg;
	assign cause_lop_next   = enable_reg && pointer_defects.lop_defect && !trail_fail_input;
	assign events = {cause_alarm_next ? 1'b0 : server_fail_action && enable_reg,
	                 cause_lop_next, cause_alarm_next};

	// Legal index ranges; members ignored in VC-2 mode
	assign sel_legal = (group_sel_reg >= lvps_pkg::LVPS_GROUP_MIN)
	                   && (group_sel_reg <= lvps_pkg::LVPS_GROUP_MAX)
	                   && ((mode_reg == lvps_pkg::LVPS_MODE_VC2)
	                       || ((member_sel_reg >= lvps_pkg::LVPS_MEMBER_MIN)
	                           && (member_sel_reg <= lvps_pkg::LVPS_MEMBER_MAX)));
	// Slot match on the tributary being presented this byte time
	assign slot_match = sel_legal && (group_slot_index == group_sel_reg)
	                    && ((mode_reg == lvps_pkg::LVPS_MODE_VC2)
	                        || (member_slot_index == member_sel_reg));

	// ************************************************************
	// Client output path
	// ************************************************************
	// Insert flag is one stage, so the switch is at most two cycles, far below 1 ms
	always_ff @(posedge clk) begin
		if (srst) begin
			insert_reg <= 1'b1;
		end else begin
			insert_reg <= alarm_insert_action;
		end
	end

	// Timing kept during substitution so downstream stays aligned
	always_ff @(posedge clk) begin
		if (srst) begin
			client_data_out <= '0;
		end else begin
			client_data_out.valid       <= group_data_in.valid && slot_match;
			client_data_out.frame_start <= group_data_in.valid && slot_match
			                               && vc_phase_start;
			if (insert_reg || alarm_insert_action) begin
				client_data_out.data <= 8'hff;
			end else if (group_data_in.valid && slot_match) begin
				client_data_out.data <= group_data_in.data;
			end
		end
	end

	// Management outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			client_server_fail_out   <= 1'b0;
			alarm_fault_cause        <= 1'b0;
			pointer_loss_fault_cause <= 1'b0;
		end else begin
			client_server_fail_out   <= server_fail_action;
			alarm_fault_cause        <= cause_alarm_next;
			pointer_loss_fault_cause <= cause_lop_next;
		end
	end

	// ************************************************************
	// Interrupt status and mask
	// ************************************************************
	// Set wins over a write-one clear in the same cycle
	always_comb begin
		irq_sts_next = irq_sts_reg;
		if (wr_en && paddr == lvps_pkg::LVPS_IRQ_STS_OFS) begin
			irq_sts_next = irq_sts_reg & ~pwdata[2:0];
		end
		irq_sts_next = irq_sts_next | events;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			irq_sts_reg <= lvps_pkg::LVPS_IRQ_RESET;
			irq         <= 1'b0;
		end else begin
			irq_sts_reg <= irq_sts_next;
			irq         <= |(irq_sts_next & irq_msk_reg);
		end
	end

	// ************************************************************
	// APB register writes
	// ************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			enable_reg     <= lvps_pkg::LVPS_CTRL_RESET[lvps_pkg::LVPS_CTRL_ENABLE_BIT];
			report_reg     <= lvps_pkg::LVPS_CTRL_RESET[lvps_pkg::LVPS_CTRL_REPORT_BIT];
			mode_reg       <= lvps_pkg::LVPS_MODE_VC12;
			group_sel_reg  <= lvps_pkg::LVPS_SEL_RESET[4:0];
			member_sel_reg <= lvps_pkg::LVPS_SEL_RESET[9:8];
			irq_msk_reg    <= lvps_pkg::LVPS_IRQ_RESET;
		end else if (wr_en) begin
			unique case (paddr)
				lvps_pkg::LVPS_CTRL_OFS: begin
					enable_reg <= pwdata[lvps_pkg::LVPS_CTRL_ENABLE_BIT];
					report_reg <= pwdata[lvps_pkg::LVPS_CTRL_REPORT_BIT];
					// Unused mode code falls back to VC-12
					unique case (pwdata[lvps_pkg::LVPS_CTRL_MODE_LSB +: 2])
						2'h0:    mode_reg <= lvps_pkg::LVPS_MODE_VC2;
						2'h2:    mode_reg <= lvps_pkg::LVPS_MODE_VC11;
						default: mode_reg <= lvps_pkg::LVPS_MODE_VC12;
					endcase
				end
				lvps_pkg::LVPS_SEL_OFS: begin
					group_sel_reg  <= pwdata[lvps_pkg::LVPS_SEL_GROUP_LSB +: 5];
					member_sel_reg <= pwdata[lvps_pkg::LVPS_SEL_MEMBER_LSB +: 2];
				end
				lvps_pkg::LVPS_IRQ_MSK_OFS: begin
					irq_msk_reg <= pwdata[2:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// APB read mux and answer
	// ************************************************************
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (paddr)
			lvps_pkg::LVPS_CTRL_OFS: begin
				rd_word[lvps_pkg::LVPS_CTRL_ENABLE_BIT] = enable_reg;
				rd_word[lvps_pkg::LVPS_CTRL_REPORT_BIT] = report_reg;
				rd_word[lvps_pkg::LVPS_CTRL_MODE_LSB +: 2] = mode_reg;
			end
			lvps_pkg::LVPS_SEL_OFS: begin
				rd_word[lvps_pkg::LVPS_SEL_GROUP_LSB +: 5]  = group_sel_reg;
				rd_word[lvps_pkg::LVPS_SEL_MEMBER_LSB +: 2] = member_sel_reg;
			end
			lvps_pkg::LVPS_STATE_OFS: begin
				rd_word[5:0] = {sel_legal, insert_reg, pointer_loss_fault_cause,
				                alarm_fault_cause, client_server_fail_out, trail_fail_input};
			end
			lvps_pkg::LVPS_IRQ_STS_OFS: rd_word[2:0] = irq_sts_reg;
			lvps_pkg::LVPS_IRQ_MSK_OFS: rd_word[2:0] = irq_msk_reg;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// One wait state: ready rises in the second access cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			prdata  <= rd_en ? rd_word : 32'h0000_0000;
			pslverr <= psel && penable && !pready && (paddr > lvps_pkg::LVPS_IRQ_MSK_OFS || paddr[1:0] != 2'h0);
		end
	end

endmodule : lvps_sink

// ==== testbench/lvps_sink_chk.sv ====
`timescale 1ns/10ps
// ****
// Port checker for the sink
// ****
module lvps_sink_chk (
	input wire logic                      clk,
	input wire logic                      srst,
	input wire logic                      pready,
	input wire lvps_pkg::lvps_stream_type group_data_in,
	input wire logic                      trail_fail_input,
	input wire lvps_pkg::lvps_defect_type pointer_defects,
	input wire logic                      vc_phase_start,
	input wire lvps_pkg::lvps_stream_type client_data_out,
	input wire logic                      client_server_fail_out,
	input wire logic                      alarm_fault_cause,
	input wire logic                      pointer_loss_fault_cause
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic bad;
	// Any defect cause for all-ones; the disabled state is not included
	assign bad = pointer_defects.alarm_defect | pointer_defects.lop_defect | trail_fail_input;
	a_srv_fail: assert property (!$past(srst) |-> client_server_fail_out == $past(bad))
		else $error("server fail not tracking defects");
	a_fill_ones: assert property ($past(bad) && client_data_out.valid |-> client_data_out.data == 8'hff)
		else $error("data not all-ones during insert");
	a_alarm_gate: assert property (alarm_fault_cause |-> $past(pointer_defects.alarm_defect && !trail_fail_input))
		else $error("alarm cause without its defect");
	a_lop_gate: assert property (pointer_loss_fault_cause |-> $past(pointer_defects.lop_defect && !trail_fail_input))
		else $error("pointer loss cause without its defect");
	a_cause_sf: assert property (alarm_fault_cause || pointer_loss_fault_cause |-> client_server_fail_out)
		else $error("cause raised without server fail");
	a_valid_src: assert property (client_data_out.valid |-> $past(group_data_in.valid))
		else $error("output byte without input byte");
	a_phase_src: assert property (client_data_out.frame_start |-> $past(vc_phase_start))
		else $error("frame start without phase mark");
	a_ack_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
endmodule : lvps_sink_chk
bind lvps_sink lvps_sink_chk u_lvps_sink_chk (.clk(clk), .srst(srst), .pready(pready), .group_data_in(group_data_in),
	.trail_fail_input(trail_fail_input), .pointer_defects(pointer_defects), .vc_phase_start(vc_phase_start),
	.client_data_out(client_data_out), .client_server_fail_out(client_server_fail_out),
	.alarm_fault_cause(alarm_fault_cause), .pointer_loss_fault_cause(pointer_loss_fault_cause));

// ==== testbench/lvps_far_end.sv ====
`timescale 1ns/10ps
// ****
// Group access point stream source
// ****
module lvps_far_end (
	input wire logic                 clk,
	input wire logic                 srst,
	input wire logic                 slow,
	output lvps_pkg::lvps_stream_type stream,
	output logic [4:0]               group_idx,
	output logic [1:0]               member_idx,
	output logic                     phase
);
	logic [7:0] cnt_reg;
	logic       vld;
	// Idle bytes still change data every cycle, so stale values never pass
	assign vld    = !(slow && cnt_reg[0]);
	assign phase  = vld && cnt_reg[3:0] == 4'h0;
	assign stream = {cnt_reg, phase, vld};
	// Slot walk, group fastest
	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_reg    <= 8'h00;
			group_idx  <= 5'h01;
			member_idx <= 2'h1;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			if (vld) begin
				group_idx <= (group_idx == 5'h14) ? 5'h01 : group_idx + 5'h01;
				if (group_idx == 5'h14)
					member_idx <= (member_idx == 2'h3) ? 2'h1 : member_idx + 2'h1;
			end
		end
	end
endmodule : lvps_far_end

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
// ****
// Sink testbench
// ****
module tb_top;
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, tf = 0, slow = 0, er, irq, sf, ac, lc, ph, a;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd, prdata;
	logic pready, pslverr;
	lvps_pkg::lvps_stream_type gd, cd;
	lvps_pkg::lvps_defect_type pd = '0;
	logic [4:0] gi;
	logic [1:0] mi;
	int fails = 0, total_checks = 0, cyc = 0;
	always #10 clk = ~clk;
	lvps_far_end u_lvps_far_end (.clk(clk), .srst(srst), .slow(slow), .stream(gd), .group_idx(gi),
		.member_idx(mi), .phase(ph));
	lvps_sink u_lvps_sink (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.group_data_in(gd), .group_slot_index(gi), .member_slot_index(mi), .trail_fail_input(tf),
		.pointer_defects(pd), .vc_phase_start(ph), .client_data_out(cd), .client_server_fail_out(sf),
		.alarm_fault_cause(ac), .pointer_loss_fault_cause(lc), .irq(irq));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	// One APB transfer; waits for ready, no fixed latency assumed
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// Compare each client byte with the input byte one edge earlier
	task automatic watch(input int n, input logic [4:0] g, input logic [1:0] m, input logic vc2, input logic ones);
		lvps_pkg::lvps_stream_type p;
		logic hit;
		repeat (n) begin
			@(posedge clk);
			p = gd;
			hit = p.valid && gi == g && (vc2 || mi == m);
			@(negedge clk);
			cmp(cd.valid, hit);
			if (hit) cmp(cd.data, ones ? 8'hff : p.data);
		end
		@(posedge clk);
	endtask : watch
	task automatic t_regs;
		apb(0, lvps_pkg::LVPS_CTRL_OFS, 0);
		cmp(rd & 32'h3, 0);
		apb(0, lvps_pkg::LVPS_SEL_OFS, 0);
		cmp(rd, lvps_pkg::LVPS_SEL_RESET);
		apb(0, 12'h014, 0);
		cmp(rd, 0);
		cmp(er, 1);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_off;
		apb(1, lvps_pkg::LVPS_SEL_OFS, 32'h0205);
		pd <= 2'b11;
		watch(130, 5'h05, 2'h2, 0, 1);
		cmp({ac, lc, sf}, 3'b001);
		pd <= 2'b00;
		$display("t_off done");
	endtask : t_off
	task automatic t_modes;
		for (int md = 0; md < 3; md++) begin
			slow <= (md == 1);
			apb(1, lvps_pkg::LVPS_SEL_OFS, md == 1 ? 32'h0314 : 32'h0205);
			apb(1, lvps_pkg::LVPS_CTRL_OFS, 32'h1 | (32'(md) << 4));
			repeat (2) @(posedge clk);
			watch(130, md == 1 ? 5'h14 : 5'h05, md == 1 ? 2'h3 : 2'h2, md == 0, 0);
		end
		slow <= 0;
		$display("t_modes done");
	endtask : t_modes
	task automatic t_defects;
		for (int k = 0; k < 4; k++) begin
			apb(1, lvps_pkg::LVPS_CTRL_OFS, k == 0 ? 32'h11 : 32'h13);
			pd <= {k != 2, k >= 2};
			tf <= (k == 3);
			repeat (2) @(posedge clk);
			@(negedge clk);
			cmp({sf, ac, lc}, {1'b1, k == 1, k == 2});
			watch(70, 5'h05, 2'h2, 0, 1);
			pd <= 2'b00;
			tf <= 0;
			repeat (3) @(posedge clk);
			watch(70, 5'h05, 2'h2, 0, 0);
			cmp(sf, 0);
		end
		$display("t_defects done");
	endtask : t_defects
	task automatic t_irq;
		apb(1, lvps_pkg::LVPS_IRQ_STS_OFS, 32'h7);
		pd <= 2'b01;
		repeat (4) @(posedge clk);
		pd <= 2'b00;
		apb(0, lvps_pkg::LVPS_IRQ_STS_OFS, 0);
		cmp(rd[1], 1);
		apb(1, lvps_pkg::LVPS_IRQ_MSK_OFS, 32'h0);
		repeat (2) @(posedge clk);
		a = irq;
		apb(1, lvps_pkg::LVPS_IRQ_MSK_OFS, 32'h7);
		repeat (2) @(posedge clk);
		cmp(a ^ irq, 1);
		apb(1, lvps_pkg::LVPS_IRQ_STS_OFS, 32'h7);
		apb(0, lvps_pkg::LVPS_IRQ_STS_OFS, 0);
		cmp({rd[2:0], irq}, 0);
		$display("t_irq done");
	endtask : t_irq
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		srst <= 0;
		t_regs();
		t_off();
		t_modes();
		t_defects();
		t_irq();
		tally_and_finish();
	end
endmodule : tb_top
